// ### pkg/cie_pkg.sv
// Shared constants and types for the core instruction execution block.
// Assumes one core clock domain; memories answer combinationally.
package cie_pkg;

   // Data-space addresses of the pointer and working registers
   localparam logic [7:0]  PTR_X_ADDR  = 8'h80;
   localparam logic [7:0]  PTR_Y_ADDR  = 8'h81;
   localparam logic [7:0]  WREG_BASE   = 8'h80;

   // Reset values
   localparam logic [11:0] PC_RESET    = 12'h000;
   localparam logic [7:0]  ACC_RESET   = 8'h00;

   // Opcode classes, held in opcode bits 3:0 (odd codes; even codes branch on a flag)
   localparam logic [3:0]  CLS_CALL    = 4'h1;
   localparam logic [3:0]  CLS_FAR     = 4'h9;
   localparam logic [3:0]  CLS_BTEST   = 4'h3;
   localparam logic [3:0]  CLS_BMOD    = 4'hB;
   localparam logic [3:0]  CLS_SHORT   = 4'h5;
   localparam logic [3:0]  CLS_ALUMEM  = 4'h7;
   localparam logic [3:0]  CLS_LIT     = 4'hD;
   localparam logic [3:0]  CLS_MEMUN   = 4'hF;

   // Two-operand operations, opcode bits 7:6
   localparam logic [1:0]  ALU_SUM     = 2'h0;
   localparam logic [1:0]  ALU_AND     = 2'h1;
   localparam logic [1:0]  ALU_CMP     = 2'h2;
   localparam logic [1:0]  ALU_MINUS   = 2'h3;

   // Single-operand operations
   localparam logic [1:0]  UN_STEPUP   = 2'h0;
   localparam logic [1:0]  UN_STEPDN   = 2'h1;
   localparam logic [1:0]  UN_ZERO     = 2'h2;

   // Inherent operations, opcode bits 6:4 with bit 7 set in the short class
   localparam logic [2:0]  INH_INVERT  = 3'h0;
   localparam logic [2:0]  INH_ROTATE  = 3'h1;
   localparam logic [2:0]  INH_SHIFT   = 3'h2;
   localparam logic [2:0]  INH_IDLE    = 3'h3;
   localparam logic [2:0]  INH_SUBEXIT = 3'h4;
   localparam logic [2:0]  INH_INTEXIT = 3'h5;
   localparam logic [2:0]  INH_STOP    = 3'h6;
   localparam logic [2:0]  INH_WAIT    = 3'h7;

   // Cycle counts per instruction group
   localparam logic [2:0]  CYC_ALU     = 3'h4;
   localparam logic [2:0]  CYC_FLAGBR  = 3'h2;
   localparam logic [2:0]  CYC_BITBR   = 3'h5;
   localparam logic [2:0]  CYC_BITMOD  = 3'h4;
   localparam logic [2:0]  CYC_CTRL    = 3'h2;
   localparam logic [2:0]  CYC_FAR     = 3'h4;

   typedef enum logic {
      ST_RUN  = 1'b0,
      ST_HALT = 1'b1
   } cie_state_t;

   typedef struct packed {
      logic zero;
      logic carry;
   } cie_flags_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       we;
   } cie_dm_req_t;

endpackage

// ### logic/cie_core.sv
// Decode and execute sequencer for the 8-bit core.
// Assumes program and data memories read combinationally from the
// registered addresses; a data write commits at the edge after dmReq.we rises.
//
// How it works
// [RULE_01] Two-operand ops: accumulator plus memory or literal
// [RULE_02] Single-operand memory ops reach all 256 locations
// [RULE_03] Invert, rotate, shift act on accumulator only
// [RULE_04] ALU ops take 4 cycles; conjunction keeps carry
// [RULE_05] Step up/down change zero, never carry
// [RULE_06] Flag branches: one byte, 2 cycles, flags kept
// [RULE_07] Flag branch reach is -15 to +16
// [RULE_08] Bit-test branch: 3 bytes, 5 cycles, sets carry
// [RULE_09] Bit-test branch reach is -126 to +129
// [RULE_10] Bit set/clear any bit, 4 cycles
// [RULE_11] Control ops: 2 cycles; interrupt exit restores flags
// [RULE_12] Hardware watchdog turns stop into wait
// [RULE_13] Call and far jump: 12-bit target, 4 cycles
// [RULE_14] Indirect address from X or Y by bit 4
// [RULE_15] Short-direct reaches X, Y, V, W at 80H-83H
// [RULE_16] Zero flags zero result; carry is carry/borrow
`timescale 1ns/1ps

module cie_core #(
   parameter int STACK_DEPTH = 6                  // Return-address cells
) (
   input  wire logic                mclk,         // Core clock, 40 MHz
   input  wire logic                rst_n,        // Asynchronous reset, active low
   output logic [11:0]              pmAddr,       // Program memory address
   input  wire logic [7:0]          pmData,       // Program memory byte at pmAddr
   output cie_pkg::cie_dm_req_t     dmReq,        // Data-space address, write data, strobe
   input  wire logic [7:0]          dmRdata,      // Data-space byte at dmReq.addr
   input  wire logic                wdogHw,       // Hardware watchdog option selected
   input  wire logic                wake,         // Leaves stop or wait, one-cycle pulse
   input  wire cie_pkg::cie_flags_t resumeFlags,  // Flags saved by the interrupt logic
   output logic [7:0]               acc,          // Accumulator
   output cie_pkg::cie_flags_t      flags,        // Zero and carry flags
   output logic                     stopped,      // Core in stop mode
   output logic                     waiting,      // Core in wait mode
   output logic                     instrDone     // Pulse after each instruction
);

   localparam int SPW = $clog2(STACK_DEPTH + 1);

   cie_pkg::cie_state_t state;
   logic [11:0]         pc;
   logic [7:0]          opc;
   logic [7:0]          opnd;
   logic [7:0]          data;
   logic [7:0]          disp;
   logic [2:0]          step;
   logic [11:0]         stack [STACK_DEPTH];
   logic [SPW-1:0]      sp;

   // Decode: step 0 looks at the byte on the bus, later steps at the latch
   wire        running   = (state == cie_pkg::ST_RUN);
   wire [7:0]  curOp     = (step == 3'h0) ? pmData : opc;
   wire [3:0]  cls       = curOp[3:0];
   wire        isFlagBr  = ~curOp[0];
   wire        isCall    = (cls == cie_pkg::CLS_CALL);
   wire        isFar     = isCall | (cls == cie_pkg::CLS_FAR);
   wire        isBTest   = (cls == cie_pkg::CLS_BTEST);
   wire        isBMod    = (cls == cie_pkg::CLS_BMOD);
   wire        isShort   = (cls == cie_pkg::CLS_SHORT) & ~curOp[7];
   wire        isInh     = (cls == cie_pkg::CLS_SHORT) & curOp[7];
   wire        isAluMem  = (cls == cie_pkg::CLS_ALUMEM);
   wire        isLit     = (cls == cie_pkg::CLS_LIT) & (curOp[5:4] == 2'h0);
   wire        isAccUn   = (cls == cie_pkg::CLS_LIT) & (curOp[5:4] == 2'h1);
   wire        isMemUn   = (cls == cie_pkg::CLS_MEMUN) & (curOp[7:6] != 2'h3);
   wire        memForm   = isAluMem | isMemUn;
   wire        isDirect  = memForm & curOp[5];
   wire        isIndir   = memForm & ~curOp[5];
   wire [2:0]  inhOp     = curOp[6:4];
   wire        inhAlu    = isInh & (inhOp <= cie_pkg::INH_SHIFT);
   wire        needByte2 = isFar | isBTest | isBMod | isLit | isDirect;
   wire [2:0]  bitIdx    = curOp[7:5];
   wire [7:0]  bitMask   = 8'h01 << bitIdx;

   // Cycle count per group
   wire [2:0]  cycles    = isFlagBr ? cie_pkg::CYC_FLAGBR :             // RULE_06
                           isBTest  ? cie_pkg::CYC_BITBR :              // RULE_08
                           isBMod   ? cie_pkg::CYC_BITMOD :             // RULE_10
                           isFar    ? cie_pkg::CYC_FAR :                // RULE_13
                           (isInh & ~inhAlu) ? cie_pkg::CYC_CTRL :      // RULE_11
                           (isShort | inhAlu | isAluMem | isLit | isAccUn | isMemUn)
                                    ? cie_pkg::CYC_ALU                  // RULE_04
                                    : cie_pkg::CYC_CTRL;
   wire        lastStep  = running & (step == cycles - 3'h1);

   // Pointer choice for indirect forms; working register for short forms
   wire [7:0]  ptrAddr   = curOp[4] ? cie_pkg::PTR_Y_ADDR : cie_pkg::PTR_X_ADDR;  // RULE_14
   wire [7:0]  shortAddr = cie_pkg::WREG_BASE | {6'h00, curOp[5:4]};             // RULE_15

   // Second operand: literal byte or data-space byte
   wire [7:0]  srcB      = isLit ? opnd : data;                         // RULE_01
   wire [8:0]  sum9      = {1'b0, acc} + {1'b0, srcB};
   wire [8:0]  dif9      = {1'b0, acc} - {1'b0, srcB};
   wire [1:0]  unOp      = isShort ? {1'b0, curOp[6]} : curOp[7:6];
   wire [7:0]  unIn      = isAccUn ? acc : data;
   wire        bitVal    = |(data & bitMask);

   // Execution result, write targets and flag updates
   logic [7:0] result;
   logic       resultCarry;
   logic       wrAcc;
   logic       wrMem;
   logic       updZ;
   logic       updC;
   always_comb begin
      result      = 8'h00;
      resultCarry = flags.carry;
      wrAcc       = 1'b0;
      wrMem       = 1'b0;
      updZ        = 1'b0;
      updC        = 1'b0;
      if (isAluMem | isLit) begin
         updZ = 1'b1;                                                   // RULE_04
         updC = (curOp[7:6] != cie_pkg::ALU_AND);                       // RULE_04
         wrAcc = (curOp[7:6] != cie_pkg::ALU_CMP);
         case (curOp[7:6])
            cie_pkg::ALU_SUM: begin
               result      = sum9[7:0];
               resultCarry = sum9[8];                                   // RULE_16
            end
            cie_pkg::ALU_AND: begin
               result = acc & srcB;
            end
            default: begin
               result      = dif9[7:0];
               resultCarry = dif9[8];                                   // RULE_16
            end
         endcase
      end else if (isShort | isMemUn | isAccUn) begin
         wrAcc = isAccUn;
         wrMem = ~isAccUn;                                              // RULE_02
         case (unOp)
            cie_pkg::UN_STEPUP: begin
               result = unIn + 8'h01;
               updZ   = 1'b1;                                           // RULE_05
            end
            cie_pkg::UN_STEPDN: begin
               result = unIn - 8'h01;
               updZ   = 1'b1;                                           // RULE_05
            end
            default: begin
               // Zeroing the accumulator clears carry; a memory byte keeps both flags
               result      = 8'h00;
               updZ        = isAccUn;
               updC        = isAccUn;
               resultCarry = 1'b0;
            end
         endcase
      end else if (inhAlu) begin
         wrAcc       = 1'b1;                                            // RULE_03
         updZ        = 1'b1;
         updC        = 1'b1;
         resultCarry = acc[7];                                          // RULE_16
         case (inhOp)
            cie_pkg::INH_INVERT: result = ~acc;
            cie_pkg::INH_ROTATE: result = {acc[6:0], flags.carry};
            default:             result = {acc[6:0], 1'b0};
         endcase
      end else if (isBMod) begin
         wrMem  = 1'b1;                                                 // RULE_10
         result = curOp[4] ? (data | bitMask) : (data & ~bitMask);
      end else if (isBTest) begin
         updC        = 1'b1;                                            // RULE_08
         resultCarry = bitVal;
      end
   end

   // Branch decisions and displacements
   logic       flagTaken;
   always_comb begin
      case (curOp[2:1])
         2'h0:    flagTaken = ~flags.zero;
         2'h1:    flagTaken = ~flags.carry;
         2'h2:    flagTaken = flags.zero;
         default: flagTaken = flags.carry;
      endcase
   end
   wire [11:0] dispShort = {{7{curOp[7]}}, curOp[7:3]};
   wire [11:0] dispLong  = {{4{disp[7]}}, disp};
   wire        bitTaken  = (bitVal == curOp[4]);                        // RULE_08
   wire [SPW-1:0] spTop  = (sp == '0) ? SPW'(STACK_DEPTH - 1) : sp - SPW'(1);  // Empty pop wraps
   wire [11:0] byteLen   = isBTest ? 12'h003 : (needByte2 ? 12'h002 : 12'h001);
   wire        isPop     = isInh & ((inhOp == cie_pkg::INH_SUBEXIT) |
                                    (inhOp == cie_pkg::INH_INTEXIT));

   // Address of the following instruction
   logic [11:0] next_pc;
   always_comb begin
      if (isFlagBr & flagTaken) begin
         next_pc = pc + 12'h001 + dispShort;                            // RULE_07
      end else if (isBTest & bitTaken) begin
         next_pc = pc + 12'h002 + dispLong;                             // RULE_09
      end else if (isFar) begin
         next_pc = {curOp[7:4], opnd};                                  // RULE_13
      end else if (isPop) begin
         next_pc = stack[spTop];
      end else begin
         next_pc = pc + byteLen;
      end
   end

   // Stop becomes wait under the hardware watchdog option
   wire        goStop = isInh & (inhOp == cie_pkg::INH_STOP) & ~wdogHw;  // RULE_12
   wire        goWait = isInh & ((inhOp == cie_pkg::INH_WAIT) |
                                 ((inhOp == cie_pkg::INH_STOP) & wdogHw));  // RULE_12

   // Step counter and run/halt state; halt holds step 0 until woken
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= cie_pkg::ST_RUN;
         step  <= 3'h0;
      end else if (!running) begin
         if (wake)
            state <= cie_pkg::ST_RUN;
      end else if (lastStep) begin
         step <= 3'h0;
         if (goStop | goWait)
            state <= cie_pkg::ST_HALT;
      end else begin
         step <= step + 3'h1;
      end
   end

   // Instruction bytes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         opc  <= 8'h00;
         opnd <= 8'h00;
         disp <= 8'h00;
         data <= 8'h00;
      end else if (running) begin
         if (step == 3'h0)
            opc <= pmData;
         if (step == 3'h1)
            opnd <= pmData;
         if (step == 3'h2) begin
            disp <= pmData;
            data <= dmRdata;
         end
      end
   end

   // Program counter and program memory address
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pc     <= cie_pkg::PC_RESET;
         pmAddr <= cie_pkg::PC_RESET;
      end else if (lastStep) begin
         pc     <= next_pc;
         pmAddr <= next_pc;
      end else if (running & (step == 3'h0) & needByte2) begin
         pmAddr <= pc + 12'h001;
      end else if (running & (step == 3'h1) & isBTest) begin
         pmAddr <= pc + 12'h002;
      end
   end

   // Data-space address and write strobe; the strobe lasts one cycle
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dmReq <= '0;
      end else begin
         dmReq.we <= lastStep & wrMem;
         if (lastStep)
            dmReq.wdata <= result;
         if (running & (step == 3'h0) & isIndir)
            dmReq.addr <= ptrAddr;                                      // RULE_14
         else if (running & (step == 3'h0) & isShort)
            dmReq.addr <= shortAddr;                                    // RULE_15
         else if (running & (step == 3'h1) & isIndir)
            dmReq.addr <= dmRdata;
         else if (running & (step == 3'h1) & (isDirect | isBMod | isBTest))
            dmReq.addr <= pmData;                                       // RULE_02
      end
   end

   // Accumulator and flags
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         acc   <= cie_pkg::ACC_RESET;
         flags <= '0;
      end else if (lastStep) begin
         if (wrAcc)
            acc <= result;
         if (isInh & (inhOp == cie_pkg::INH_INTEXIT)) begin
            flags <= resumeFlags;                                       // RULE_11
         end else begin
            if (updZ)
               flags.zero <= (result == 8'h00);                         // RULE_16
            if (updC)
               flags.carry <= resultCarry;
         end
      end
   end

   // Return stack; overflow wraps and overwrites the oldest cell
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sp <= '0;
      end else if (lastStep & isCall) begin
         stack[sp] <= pc + 12'h002;
         sp        <= (sp == SPW'(STACK_DEPTH - 1)) ? '0 : sp + SPW'(1);
      end else if (lastStep & isPop) begin
         sp <= spTop;
      end
   end

   // Status outputs
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stopped   <= 1'b0;
         waiting   <= 1'b0;
         instrDone <= 1'b0;
      end else begin
         instrDone <= lastStep;
         if (lastStep) begin
            stopped <= goStop;
            waiting <= goWait;
         end else if (!running & wake) begin
            stopped <= 1'b0;
            waiting <= 1'b0;
         end
      end
   end

endmodule

// ### sim/cie_mem_model.sv
// Program and data memory seen by the core, both read combinationally.
// Assumes the bench loads pm and dm through hierarchical references.
`timescale 1ns/1ps
module cie_mem_model (
   input  wire logic                 mclk,   // Core clock
   input  wire logic [11:0]          pmAddr, // Program address
   output logic [7:0]                pmData, // Program byte
   input  wire cie_pkg::cie_dm_req_t dmReq,  // Data request
   output logic [7:0]                dmRdata // Data byte
);
   logic [7:0] pm [4096];
   logic [7:0] dm [256];
   // Reads follow the address at once, so no stale byte lingers
   assign pmData  = pm[pmAddr];
   assign dmRdata = dm[dmReq.addr];
   // Write commits at the edge that ends the strobe cycle
   always @(posedge mclk) if (dmReq.we) dm[dmReq.addr] <= dmReq.wdata;
endmodule

// ### sim/cie_core_assertions.sv
// Timing and flag checks on the core's ports.
// Assumes the core's own opcode classes; bound to every core.
`timescale 1ns/1ps
module cie_core_checker (
   input wire logic                mclk,        // Core clock
   input wire logic                rst_n,       // Reset, active low
   input wire logic [11:0]         pmAddr,      // Program address
   input wire logic [7:0]          pmData,      // Program byte
   input wire cie_pkg::cie_dm_req_t dmReq,      // Data request
   input wire logic [7:0]          dmRdata,     // Data byte
   input wire logic                wdogHw,      // Watchdog option
   input wire logic                wake,        // Wake pulse
   input wire cie_pkg::cie_flags_t resumeFlags, // Restored flags
   input wire logic [7:0]          acc,         // Accumulator
   input wire cie_pkg::cie_flags_t flags,       // Flags
   input wire logic                stopped,     // Stop mode
   input wire logic                waiting,     // Wait mode
   input wire logic                instrDone    // End pulse
);
   logic                first, skip;
   logic [3:0]          cnt;
   logic [7:0]          op, b2;
   logic [11:0]         pc0;
   cie_pkg::cie_flags_t fl0;
   // Decode of the instruction in flight
   wire       halted = stopped || waiting;
   wire       start  = first || instrDone;
   wire       live   = instrDone && !skip;
   wire [3:0] cls    = op[3:0];
   wire       isInh  = cls == 4'h5 && op[7];
   wire       isBr   = !op[0];
   wire       isExt  = cls == 4'h1 || cls == 4'h9;
   wire       inhKp  = !(op[6:4] inside {3'h0, 3'h1, 3'h2, 3'h5});
   wire [2:0] expCyc = (isBr || (isInh && op[6:4] > 3'h2) || (cls == 4'hD && op[5])
                       || (cls == 4'hF && op[7:6] == 2'h3)) ? 3'h2 : (cls == 4'h3) ? 3'h5 : 3'h4;
   wire keepZ = isBr || isExt || cls == 4'hB || cls == 4'h3 || (isInh && inhKp)
                || (cls == 4'hD && op[5]) || (cls == 4'hF && op[7]);
   wire keepC = isBr || isExt || cls == 4'hB || (cls == 4'h5 && !op[7]) || (isInh && inhKp)
                || ((cls == 4'h7 || (cls == 4'hD && op[5:4] == 2'h0)) && op[7:6] == 2'h1)
                || (cls == 4'hD && op[5:4] != 2'h0 && !(op[5:4] == 2'h1 && op[7:6] == 2'h2))
                || cls == 4'hF;
   wire wrAcc = ((cls == 4'h7 || (cls == 4'hD && op[5:4] == 2'h0)) && op[7:6] != 2'h2)
                || (cls == 4'hD && op[5:4] == 2'h1 && op[7:6] != 2'h3)
                || (isInh && op[6:4] < 3'h3);
   wire        taken = (op[1] ? fl0.carry : fl0.zero) == op[2];
   wire [11:0] brTgt = pc0 + 12'h001 + (taken ? {{7{op[7]}}, op[7:3]} : 12'h000);
   // First instruction after a halt is skipped, its start is not visible
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         first <= 1'b1;
         skip  <= 1'b0;
      end else begin
         first <= 1'b0;
         skip  <= halted ? 1'b1 : (instrDone ? 1'b0 : skip);
      end
   end
   // Snapshot of opcode, address, flags and second byte
   always_ff @(posedge mclk) begin
      if (start) begin
         op  <= pmData;
         pc0 <= pmAddr;
         fl0 <= flags;
      end
      cnt <= start ? 4'h1 : (cnt == 4'hF ? cnt : cnt + 4'h1);
      if (cnt == 4'h1) b2 <= pmData;
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_write;
      dmReq.we && dmReq.wdata[op[7:5]] == op[4] ##1 !dmReq.we;
   endsequence
   property p_cycles; live && !(isInh && op[6:5] == 2'h3) |-> cnt == {1'b0, expCyc}; endproperty
   a_cycles: assert property (p_cycles) else $error("cycle count wrong");
   property p_keepc; live && keepC |-> flags.carry == fl0.carry; endproperty
   a_keepc: assert property (p_keepc) else $error("carry changed");
   property p_keepz; live && keepZ |-> flags.zero == fl0.zero; endproperty
   a_keepz: assert property (p_keepz) else $error("zero changed");
   property p_zero; live && wrAcc |-> flags.zero == (acc == 8'h00); endproperty
   a_zero: assert property (p_zero) else $error("zero flag wrong");
   property p_flagbr; live && isBr |-> pmAddr == brTgt; endproperty
   a_flagbr: assert property (p_flagbr) else $error("branch target wrong");
   property p_ext; live && isExt |-> pmAddr == {op[7:4], b2}; endproperty
   a_ext: assert property (p_ext) else $error("extended target wrong");
   property p_intexit;
      live && isInh && op[6:4] == 3'h5 |-> flags == $past(resumeFlags);
   endproperty
   a_intexit: assert property (p_intexit) else $error("restored flags wrong");
   property p_wdog; $rose(stopped) |-> !$past(wdogHw); endproperty
   a_wdog: assert property (p_wdog) else $error("stop under watchdog");
   property p_halt; halted && !wake |=> $stable(acc) && $stable(pmAddr); endproperty
   a_halt: assert property (p_halt) else $error("ran while halted");
   property p_bmod; live && cls == 4'hB |-> s_write; endproperty
   a_bmod: assert property (p_bmod) else $error("bit write wrong");
endmodule
bind cie_core cie_core_checker i_chk (.mclk(mclk), .rst_n(rst_n), .pmAddr(pmAddr),
   .pmData(pmData), .dmReq(dmReq), .dmRdata(dmRdata), .wdogHw(wdogHw), .wake(wake),
   .resumeFlags(resumeFlags), .acc(acc), .flags(flags), .stopped(stopped),
   .waiting(waiting), .instrDone(instrDone));

// ### sim/tb.sv
// Self-checking bench for the core with its memory model.
// Assumes combinational memories; inputs change on the falling edge.
`timescale 1ns/1ps
module tb;
   logic mclk, rst_n = 1'b0, wdogHw = 1'b0, wake = 1'b0, instrDone, stopped, waiting;
   logic [11:0] pmAddr;
   logic [7:0]  pmData, dmRdata, acc;
   cie_pkg::cie_dm_req_t dmReq;
   cie_pkg::cie_flags_t  flags, resumeFlags = 2'h0;
   int numErrors = 0, checks = 0;
   cie_core i_dut (.mclk(mclk), .rst_n(rst_n), .pmAddr(pmAddr), .pmData(pmData), .dmReq(dmReq),
      .dmRdata(dmRdata), .wdogHw(wdogHw), .wake(wake), .resumeFlags(resumeFlags), .acc(acc),
      .flags(flags), .stopped(stopped), .waiting(waiting), .instrDone(instrDone));
   cie_mem_model i_mem (.mclk(mclk), .pmAddr(pmAddr), .pmData(pmData), .dmReq(dmReq),
      .dmRdata(dmRdata));
   // Clock at 40 MHz
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         numErrors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", checks, numErrors);
      if (numErrors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Reset held while program memory is refilled with idle opcodes and data memory cleared
   task automatic hold(input logic wd);
      @(negedge mclk);
      rst_n = 1'b0;
      wdogHw = wd;
      foreach (i_mem.pm[i]) i_mem.pm[i] = 8'hB5;
      foreach (i_mem.dm[i]) i_mem.dm[i] = 8'h00;
   endtask
   task automatic go;
      repeat (20) @(negedge mclk);
      rst_n = 1'b1;
   endtask
   task automatic put(input int a, input logic [7:0] q[$]);
      foreach (q[i]) i_mem.pm[a + i] = q[i];
   endtask
   // Bounded wait for the end pulse; returns cycles taken
   task automatic step(output int g);
      g = 0;
      do begin
         @(negedge mclk);
         g++;
      end while (instrDone !== 1'b1 && g < 60);
   endtask
   task automatic flow(input int cyc, input logic [11:0] pc, input logic [1:0] fl);
      int g;
      step(g);
      check(16'(g), 16'(cyc));
      check(16'(pmAddr), 16'(pc));
      check(16'(flags), 16'(fl));
   endtask
   task automatic t_alu;
      logic [7:0] ea [10] = '{8'hF0, 8'h10, 8'h00, 8'h00, 8'h00, 8'h81, 8'h7E, 8'hFD,
                              8'hFA, 8'h00};
      logic [1:0] ef [10] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2};
      int g;
      hold(1'b0);
      put(0, '{8'h0D, 8'hF0, 8'h0D, 8'h20, 8'h4D, 8'h00, 8'h8D, 8'h01, 8'hCD, 8'h00, 8'h0D,
               8'h81, 8'h85, 8'h95, 8'hA5, 8'h9D});
      go();
      for (int i = 0; i < 10; i++) begin
         step(g);
         check(16'(g), 16'h0004);
         check(16'(acc), 16'(ea[i]));
         check(16'(flags), 16'(ef[i]));
      end
   endtask
   task automatic t_mem;
      logic [7:0] ea [5] = '{8'hFF, 8'h04, 8'h04, 8'h04, 8'h04};
      logic [1:0] ef [5] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h1};
      int g;
      hold(1'b0);
      put(0, '{8'h17, 8'h27, 8'h10, 8'h75, 8'h0F, 8'hAF, 8'hFF});
      i_mem.dm[8'h80] = 8'h10;
      i_mem.dm[8'h81] = 8'h20;
      i_mem.dm[8'h10] = 8'h05;
      i_mem.dm[8'h20] = 8'hFF;
      i_mem.dm[8'h83] = 8'h01;
      i_mem.dm[8'hFF] = 8'h5A;
      go();
      for (int i = 0; i < 5; i++) begin
         step(g);
         check(16'(g), 16'h0004);
         check(16'(acc), 16'(ea[i]));
         check(16'(flags), 16'(ef[i]));
      end
      @(negedge mclk);
      check(16'(i_mem.dm[8'h83]), 16'h0000);
      check(16'(i_mem.dm[8'h10]), 16'h0006);
      check(16'(i_mem.dm[8'hFF]), 16'h0000);
   endtask
   task automatic t_branch;
      hold(1'b0);
      put(12'h000, '{8'h78, 8'hB5, 8'h86});
      put(12'h010, '{8'h84, 8'h82});
      go();
      flow(2, 12'h010, 2'h0);
      flow(2, 12'h011, 2'h0);
      flow(2, 12'h002, 2'h0);
      flow(2, 12'h003, 2'h0);
   endtask
   task automatic t_bits;
      hold(1'b0);
      put(12'h000, '{8'hFB, 8'h40, 8'h0B, 8'h41, 8'hF3, 8'h40, 8'h7F, 8'hE3, 8'h40, 8'h00});
      put(12'h085, '{8'h03, 8'h41, 8'h80});
      i_mem.dm[8'h41] = 8'hFF;
      go();
      flow(4, 12'h002, 2'h0);
      flow(4, 12'h004, 2'h0);
      flow(5, 12'h085, 2'h1);
      flow(5, 12'h007, 2'h0);
      flow(5, 12'h00A, 2'h1);
      check(16'(i_mem.dm[8'h40]), 16'h0080);
      check(16'(i_mem.dm[8'h41]), 16'h00FE);
   endtask
   task automatic t_ctrl;
      hold(1'b0);
      resumeFlags = 2'h3;
      put(12'h000, '{8'hA1, 8'hBC, 8'hF9, 8'h00});
      put(12'hABC, '{8'hB5, 8'hC5});
      put(12'hF00, '{8'h11, 8'h23});
      put(12'h123, '{8'hD5});
      go();
      flow(4, 12'hABC, 2'h0);
      flow(2, 12'hABD, 2'h0);
      flow(2, 12'h002, 2'h0);
      flow(4, 12'hF00, 2'h0);
      flow(4, 12'h123, 2'h0);
      flow(2, 12'hF02, 2'h3);
   endtask
   task automatic halt_wait;
      for (int n = 0; n < 20 && (stopped | waiting) !== 1'b1; n++) @(negedge mclk);
   endtask
   task automatic pulse;
      wake = 1'b1;
      @(negedge mclk);
      wake = 1'b0;
   endtask
   task automatic t_halt;
      logic [11:0] p;
      hold(1'b0);
      put(12'h000, '{8'hE5, 8'hF5, 8'hB5});
      go();
      halt_wait();
      check(16'({stopped, waiting}), 16'h0002);
      p = pmAddr;
      repeat (5) @(negedge mclk);
      check(16'(pmAddr), 16'(p));
      pulse();
      halt_wait();
      check(16'({stopped, waiting}), 16'h0001);
      pulse();
      repeat (6) @(negedge mclk);
      check(16'({stopped, waiting, pmAddr > 12'h002}), 16'h0001);
      hold(1'b1);
      put(12'h000, '{8'hE5});
      go();
      halt_wait();
      check(16'({stopped, waiting}), 16'h0001);
   endtask
   // Watchdog against a hung run
   initial begin
      #(25ns * 3000);
      numErrors++;
      give_verdict();
   end
   initial begin
      t_alu();
      $display("accumulator test done");
      t_mem();
      $display("memory operand test done");
      t_branch();
      $display("flag branch test done");
      t_bits();
      $display("bit test done");
      t_ctrl();
      $display("control test done");
      t_halt();
      $display("halt test done");
      give_verdict();
   end
endmodule
